// ---- verilog/wdts_watchdog.v ----
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "wdts_map.vh"
// Summary of operation
// - the watchdog counts on its own free-running rc oscillator tick, not on the main oscillator.
// - the watchdog keeps counting while the main oscillator is stopped and the core sleeps.
// - an expiry during normal running issues a watchdog reset of the device.
// - an expiry during sleep wakes the device so it resumes normal execution instead of resetting.
// - every expiry, reset or wake-up, clears the timeout flag of the status register.
// - a cleared watchdog enable fuse keeps the watchdog off with no software way back.
// - one scaler is shared with timer0 and the assign bit decides whether it postscales the watchdog.
// - the clear and sleep instructions reset the watchdog count and an assigned postscaler count.
// - the clear instruction leaves the assign bit and the ratio field untouched.
module wdts_watchdog #(
	parameter BASE_W = `WDTS_BASE_W,
	parameter SCALE_W = 8
)(
	input wire sys_clk, // core clock, 100 MHz
	input wire reset_n, // asynchronous reset, active low
	input wire rc_osc_in, // watchdog rc oscillator, asynchronous
	input wire main_osc_input, // main oscillator running, asynchronous level
	input wire watchdog_clear_instr, // clear-watchdog instruction pulse
	input wire sleep_instr, // sleep instruction pulse
	input wire timer0_tick, // timer0 count source for the shared scaler
	input wire [`WDTS_ADDR_W-1:0] reg_addr, // register address
	input wire [7:0] reg_wdata, // register write data
	input wire reg_wr, // write strobe
	input wire reg_rd, // read strobe
	output reg [7:0] reg_rdata, // read data, valid cycle after strobe
	output reg wdt_reset_out, // watchdog reset pulse to reset logic
	output reg wake_out, // wake pulse to the core
	output reg asleep_out, // device sleep state
	output reg timer0_inc, // timer0 increment, through scaler unless the scaler is assigned to the watchdog
	output reg irq_out // level interrupt
);
	reg [1:0] rc_sync_r;
	reg rc_prev_r;
	reg [1:0] osc_sync_r;
	reg [7:0] option_r;
	reg [7:0] config_r;
	reg to_flag_r;
	reg pd_flag_r;
	reg asleep_r;
	reg [BASE_W-1:0] base_cnt_r;
	reg [SCALE_W-1:0] scale_cnt_r;
	reg [`WDTS_IRQ_W-1:0] irq_stat_r;
	reg [`WDTS_IRQ_W-1:0] irq_mask_r;
	reg [`WDTS_RST_CW-1:0] rst_cnt_r;
	reg [7:0] rdata_nxt;
	wire rc_tick;
	wire wdt_on;
	wire scaler_assign_select;
	wire [2:0] ratio;
	wire base_wrap;
	wire scale_done;
	wire expire;
	wire wdt_clear;
	wire sc_src;
	wire [SCALE_W-1:0] scale_mask;
	wire [`WDTS_IRQ_W-1:0] irq_set;
	wire wr_irq_stat;

	assign rc_tick = rc_sync_r[1] & ~rc_prev_r;
	assign wdt_on = config_r[`WDTS_CFG_WATCHDOG_FUSE_ENABLE];
	assign scaler_assign_select = option_r[`WDTS_OPT_PSA];
	assign ratio = option_r[`WDTS_OPT_PS_HI:`WDTS_OPT_PS_LO];
	// sleep and clear both restart the count; sleep is treated as a clear too
	assign wdt_clear = watchdog_clear_instr | sleep_instr;
	assign base_wrap = rc_tick & (&base_cnt_r);
	// ratio n means divide by 2^n; the low n bits must all be ones
	assign scale_mask = ~({SCALE_W{1'b1}} << ratio);
	assign sc_src = scaler_assign_select ? base_wrap : timer0_tick;
	assign scale_done = sc_src & ((scale_cnt_r & scale_mask) == scale_mask);
	assign expire = wdt_on & (scaler_assign_select ? scale_done : base_wrap) & ~wdt_clear & (rst_cnt_r == {`WDTS_RST_CW{1'b0}});
	assign irq_set = {expire & asleep_r, expire & ~asleep_r};
	assign wr_irq_stat = reg_wr & (reg_addr == `WDTS_OFS_IRQ_STAT);

	// the first stage is only read by the second stage
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rc_sync_r <= 2'h0;
			rc_prev_r <= 1'b0;
			osc_sync_r <= 2'h0;
		end
		else
		begin
			rc_sync_r <= {rc_sync_r[0], rc_osc_in};
			rc_prev_r <= rc_sync_r[1];
			osc_sync_r <= {osc_sync_r[0], main_osc_input};
		end
	end

	// the count depends only on rc ticks, so a stopped main oscillator does not stall it
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			base_cnt_r <= {BASE_W{1'b0}};
		else if (!wdt_on || wdt_clear)
			base_cnt_r <= {BASE_W{1'b0}};
		else if (rc_tick)
			base_cnt_r <= base_cnt_r + {{(BASE_W-1){1'b0}}, 1'b1};
	end

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			scale_cnt_r <= {SCALE_W{1'b0}};
		else if (scaler_assign_select && (wdt_clear || expire))
			scale_cnt_r <= {SCALE_W{1'b0}};
		else if (scale_done)
			scale_cnt_r <= {SCALE_W{1'b0}};
		else if (sc_src)
			scale_cnt_r <= scale_cnt_r + {{(SCALE_W-1){1'b0}}, 1'b1};
	end

	// option and config only change by register writes; clear never touches them
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			option_r <= `WDTS_OPT_RESET;
			config_r <= `WDTS_CFG_RESET;
			irq_mask_r <= {`WDTS_IRQ_W{1'b0}};
		end
		else if (reg_wr)
		begin
			if (reg_addr == `WDTS_OFS_OPTION || reg_addr == `WDTS_OFS_OPTION_MIRROR)
				option_r <= reg_wdata;
			// the fuse enable bit can only be cleared, never set again
			if (reg_addr == `WDTS_OFS_CONFIG)
				config_r <= reg_wdata & (config_r | ~(8'h01 << `WDTS_CFG_WATCHDOG_FUSE_ENABLE));
			if (reg_addr == `WDTS_OFS_IRQ_MASK)
				irq_mask_r <= reg_wdata[`WDTS_IRQ_W-1:0];
		end
	end

	// sleep state, status flags and reset pulse
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			asleep_r <= 1'b0;
			to_flag_r <= 1'b1;
			pd_flag_r <= 1'b1;
			rst_cnt_r <= {`WDTS_RST_CW{1'b0}};
			wdt_reset_out <= 1'b0;
			wake_out <= 1'b0;
		end
		else
		begin
			wake_out <= expire & asleep_r;
			wdt_reset_out <= (expire & ~asleep_r) | (rst_cnt_r > {{(`WDTS_RST_CW-1){1'b0}}, 1'b1});
			if (expire)
			begin
				to_flag_r <= 1'b0;
				asleep_r <= 1'b0;
				if (!asleep_r)
					rst_cnt_r <= `WDTS_RST_CYC;
			end
			else
			begin
				if (rst_cnt_r != {`WDTS_RST_CW{1'b0}})
					rst_cnt_r <= rst_cnt_r - {{(`WDTS_RST_CW-1){1'b0}}, 1'b1};
				if (sleep_instr)
				begin
					asleep_r <= 1'b1;
					pd_flag_r <= 1'b0;
					to_flag_r <= 1'b1;
				end
				else if (watchdog_clear_instr)
				begin
					to_flag_r <= 1'b1;
					pd_flag_r <= 1'b1;
				end
			end
		end
	end

	// sticky events; a new event wins over a write-one clear
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_stat_r <= {`WDTS_IRQ_W{1'b0}};
			irq_out <= 1'b0;
		end
		else
		begin
			irq_stat_r <= (irq_stat_r & ~(wr_irq_stat ? reg_wdata[`WDTS_IRQ_W-1:0] : {`WDTS_IRQ_W{1'b0}})) | irq_set;
			irq_out <= |((irq_stat_r | irq_set) & irq_mask_r &
				~((wr_irq_stat ? reg_wdata[`WDTS_IRQ_W-1:0] : {`WDTS_IRQ_W{1'b0}}) & ~irq_set));
		end
	end

	always @*
	begin
		rdata_nxt = 8'h00;
		case (reg_addr)
			`WDTS_OFS_OPTION, `WDTS_OFS_OPTION_MIRROR: rdata_nxt = option_r;
			`WDTS_OFS_CONFIG: rdata_nxt = config_r;
			`WDTS_OFS_STATUS: rdata_nxt = ({7'h00, to_flag_r} << `WDTS_STAT_TO) | ({7'h00, pd_flag_r} << `WDTS_STAT_PD);
			`WDTS_OFS_IRQ_STAT: rdata_nxt = {{(8-`WDTS_IRQ_W){1'b0}}, irq_stat_r};
			`WDTS_OFS_IRQ_MASK: rdata_nxt = {{(8-`WDTS_IRQ_W){1'b0}}, irq_mask_r};
			default: rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reg_rdata <= 8'h00;
			asleep_out <= 1'b0;
			timer0_inc <= 1'b0;
		end
		else
		begin
			reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
			asleep_out <= asleep_r & ~expire;
			// timer0 sees the undivided tick when the scaler belongs to the watchdog
			timer0_inc <= scaler_assign_select ? timer0_tick : scale_done;
		end
	end
endmodule

// ---- verilog/wdts_map.vh ----
`ifndef WDTS_MAP_VH
`define WDTS_MAP_VH
// register offsets on the plain register port
`define WDTS_ADDR_W 14
`define WDTS_OFS_OPTION 14'h0081
`define WDTS_OFS_OPTION_MIRROR 14'h0181
`define WDTS_OFS_CONFIG 14'h2007
`define WDTS_OFS_STATUS 14'h0003
`define WDTS_OFS_IRQ_STAT 14'h0040
`define WDTS_OFS_IRQ_MASK 14'h0041
// option register fields
`define WDTS_OPT_PSA 3
`define WDTS_OPT_PS_HI 2
`define WDTS_OPT_PS_LO 0
`define WDTS_OPT_RESET 8'hFF
// configuration word fields
`define WDTS_CFG_WATCHDOG_FUSE_ENABLE 2
`define WDTS_CFG_RESET 8'hFF
// status register fields
`define WDTS_STAT_PD 3
`define WDTS_STAT_TO 4
// interrupt status bits
`define WDTS_IRQ_RESET 0
`define WDTS_IRQ_WAKE 1
`define WDTS_IRQ_W 2
// watchdog base count width and reset pulse length
`define WDTS_BASE_W 8
`define WDTS_RST_CYC 4'h4
`define WDTS_RST_CW 4
`endif

// ---- tb/wdts_rc_model.sv ----
`timescale 1ns/10ps
module wdts_rc_model (
	output logic rc_osc // rc oscillator, 70 ns period
);
	// free running and unrelated to sys_clk; it keeps going while the core sleeps
	initial
	begin
		rc_osc = 1'b0;
		forever #35 rc_osc = ~rc_osc;
	end
endmodule

// ---- tb/wdts_watchdog_sva.sv ----
`timescale 1ns/10ps
`include "wdts_map.vh"
module wdts_watchdog_sva #(
	parameter BASE_W = 8,
	parameter SCALE_W = 8
)(
	input wire sys_clk,
	input wire reset_n,
	input wire rc_osc_in,
	input wire main_osc_input,
	input wire watchdog_clear_instr,
	input wire sleep_instr,
	input wire timer0_tick,
	input wire [`WDTS_ADDR_W-1:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire wdt_reset_out,
	input wire wake_out,
	input wire asleep_out,
	input wire timer0_inc,
	input wire irq_out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	chk_wake_pulse: assert property (wake_out |=> !wake_out)
		else $error("wake pulse too long");
	chk_wake_asleep: assert property (wake_out |-> $past(asleep_out))
		else $error("wake while awake");
	chk_wake_resume: assert property (wake_out |-> ##[0:2] !asleep_out)
		else $error("sleep not left");
	chk_reset_awake: assert property ($rose(wdt_reset_out) |-> !$past(asleep_out))
		else $error("reset during sleep");
	chk_reset_len: assert property ($rose(wdt_reset_out) |-> wdt_reset_out[*3])
		else $error("reset pulse short");
	chk_clear_quiet: assert property ((watchdog_clear_instr || sleep_instr) |=> (!wake_out && !$rose(wdt_reset_out))[*4])
		else $error("expiry after clear");
	chk_one_cause: assert property (!(wdt_reset_out && wake_out))
		else $error("reset and wake together");
	chk_sleep_enter: assert property (sleep_instr |-> ##2 asleep_out)
		else $error("sleep not entered");
	chk_t0_cause: assert property ($rose(timer0_inc) |-> $past(timer0_tick) || $past(timer0_tick, 2))
		else $error("timer0 step without tick");
	cov_reset: cover property ($rose(wdt_reset_out));
	cov_wake: cover property (wake_out);
	cov_irq: cover property ($rose(irq_out));
endmodule
bind wdts_watchdog wdts_watchdog_sva #(.BASE_W(BASE_W), .SCALE_W(SCALE_W)) u_chk (.*);

// ---- tb/test_wdts_watchdog.sv ----
`timescale 1ns/10ps
`include "wdts_map.vh"
module test_wdts_watchdog;
	logic sys_clk, reset_n, clr, slp, t0, rd, wr, mosc;
	logic [`WDTS_ADDR_W-1:0] addr;
	logic [7:0] wdata, got;
	wire [7:0] rdata;
	wire wrst, wake, asleep, t0inc, irq, rc;
	int mismatches, comparisons, n, i, incs;
	logic [7:0] opt [4] = '{8'hF8, 8'hF9, 8'hFA, 8'hF7};
	int tks [4] = '{8, 16, 32, 8};
	wdts_rc_model u_rc (.rc_osc(rc));
	wdts_watchdog #(.BASE_W(3)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .rc_osc_in(rc), .main_osc_input(mosc),
		.watchdog_clear_instr(clr), .sleep_instr(slp), .timer0_tick(t0), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .wdt_reset_out(wrst), .wake_out(wake), .asleep_out(asleep),
		.timer0_inc(t0inc), .irq_out(irq));
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) if (t0inc) incs++;
	task wr8(input logic [13:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task rd8(input logic [13:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task cmp(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// issue a clear (0) or a sleep (1) instruction as a one-cycle pulse
	task instr(input bit s);
		@(posedge sys_clk);
		if (s) slp <= 1'b1;
		else clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		slp <= 1'b0;
	endtask
	task waitx(output int c);
		c = 0;
		while (!(wrst || wake) && c < 1000)
		begin
			@(posedge sys_clk);
			#1;
			c++;
		end
	endtask
	task test_done;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		{reset_n, clr, slp, t0, rd, wr, addr, wdata} = '0;
		mosc = 1'b1;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd8(`WDTS_OFS_OPTION); cmp(got, 8'hFF);
		rd8(`WDTS_OFS_CONFIG); cmp(got, 8'hFF);
		rd8(14'h0055); cmp(got, 8'h00);
		wr8(`WDTS_OFS_IRQ_MASK, 8'h01);
		for (i = 0; i < 4; i++)
		begin
			wr8(`WDTS_OFS_OPTION, opt[i]);
			instr(0);
			waitx(n);
			cmp({7'h0, n > tks[i] * 7 - 10 && n < tks[i] * 7 + 12}, 8'h01);
			cmp({7'h0, wrst}, 8'h01);
			rd8(`WDTS_OFS_STATUS); cmp(got & 8'h10, 8'h00);
			cmp({7'h0, irq}, 8'h01);
			wr8(`WDTS_OFS_IRQ_STAT, 8'h01);
		end
		repeat (20)
		begin
			repeat (30) @(posedge sys_clk);
			instr(0);
		end
		rd8(`WDTS_OFS_STATUS); cmp(got & 8'h10, 8'h10);
		rd8(`WDTS_OFS_OPTION); cmp(got, 8'hF7);
		cmp({7'h0, irq}, 8'h00);
		instr(1);
		mosc <= 1'b0;
		waitx(n);
		cmp({7'h0, wake}, 8'h01);
		mosc <= 1'b1;
		rd8(`WDTS_OFS_STATUS); cmp(got & 8'h10, 8'h00);
		cmp({7'h0, irq}, 8'h00);
		rd8(`WDTS_OFS_IRQ_STAT); cmp(got & 8'h03, 8'h02);
		wr8(`WDTS_OFS_IRQ_MASK, 8'h03);
		@(posedge sys_clk);
		#1 cmp({7'h0, irq}, 8'h01);
		wr8(`WDTS_OFS_IRQ_STAT, 8'h02);
		@(posedge sys_clk);
		#1 cmp({7'h0, irq}, 8'h00);
		// first pass: scaler on the watchdog, timer0 undivided; second pass: timer0 divided by two
		for (i = 0; i < 2; i++)
		begin
			wr8(`WDTS_OFS_OPTION, (i != 0) ? 8'hF1 : 8'hF8);
			instr(0);
			incs = 0;
			repeat (8)
			begin
				t0 <= 1'b1;
				@(posedge sys_clk);
				t0 <= 1'b0;
				@(posedge sys_clk);
			end
			@(posedge sys_clk);
			cmp(incs[7:0], (i != 0) ? 8'h04 : 8'h08);
		end
		wr8(`WDTS_OFS_CONFIG, 8'hFB);
		wr8(`WDTS_OFS_CONFIG, 8'hFF);
		rd8(`WDTS_OFS_CONFIG); cmp(got, 8'hFB);
		instr(0);
		waitx(n);
		cmp({7'h0, wrst | wake}, 8'h00);
		test_done;
	end
	initial
	begin
		#100000;
		mismatches++;
		test_done;
	end
endmodule
